/* common/alfi_pkg.sv */
package alfi_pkg;
  // ==========================================================
  // Link timing
  localparam int unsigned FRAME_NS_X1000 = 20833;
  localparam int unsigned BIT_CLK_KHZ = 24000;
  localparam int unsigned FRAME_BITS = (FRAME_NS_X1000 * BIT_CLK_KHZ + 500000) / 1000000;
  localparam int unsigned POS_W = $clog2(FRAME_BITS);
  localparam int unsigned SYNC_MARK_CLKS = 4;
  localparam int unsigned INIT_SYNC_LIMIT = 25;
  // ==========================================================
  // Field layout
  localparam int unsigned CMD_BITS = 40;
  localparam int unsigned CMD_PAIRS = CMD_BITS / 2;
  localparam int unsigned RSP_BITS = 36;
  localparam int unsigned OUT_TAG_HALVES = 8;
  localparam int unsigned IN_TAG_BITS = 10;
  localparam int unsigned SID_W = 4;
  localparam int unsigned LEN_W = 6;
  localparam logic [3:0] OUT_PREAMBLE = 4'he;
  localparam logic [3:0] ADDR_MAX = 4'he;
  localparam logic [5:0] SYNC_LAST_CLK = 6'h3f;
  // ==========================================================
  // Link phases after reset
  typedef enum logic [2:0] {
    L_CONNECT,
    L_TURN,
    L_ADDR,
    L_READY,
    L_NORMAL
  } alfi_phase_type;
endpackage

/* common/alfi_xfer_if.sv */
`timescale 1ns/1ns
interface alfi_xfer_if #(parameter int W = 8);
  logic src_valid;
  logic [W-1:0] src_data;
  logic src_busy;
  logic dst_valid;
  logic [W-1:0] dst_data;
  modport src (output src_valid, output src_data, input src_busy);
  modport dst (input dst_valid, input dst_data);
  modport cdc (input src_valid, input src_data, output src_busy, output dst_valid,
    output dst_data);
endinterface

/* hdl/alfi_xfer_cdc.sv */
`timescale 1ns/1ns
module alfi_xfer_cdc #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic dst_clk,
  input wire logic dst_rst,
  alfi_xfer_if.cdc x
);
  import alfi_pkg::*;

  // ==========================================================
  // Toggle handshake; hold stays still until the far side acks
  typedef struct packed {
    logic req;
    logic [W-1:0] hold;
    logic [1:0] ack_sy;
  } alfi_src_type;

  typedef struct packed {
    logic [2:0] req_sy;
    logic valid;
    logic [W-1:0] data;
  } alfi_dst_type;

  alfi_src_type s_q;
  alfi_src_type s_d;
  alfi_dst_type d_q;
  alfi_dst_type d_d;

  assign x.src_busy = s_q.req ^ s_q.ack_sy[1];
  assign x.dst_valid = d_q.valid;
  assign x.dst_data = d_q.data;

  always_comb begin
    s_d = s_q;
    s_d.ack_sy = {s_q.ack_sy[0], d_q.req_sy[2]};
    if (x.src_valid && !x.src_busy) begin
      s_d.req = ~s_q.req;
      s_d.hold = x.src_data;
    end
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    d_d = d_q;
    d_d.req_sy = {d_q.req_sy[1:0], s_q.req};
    d_d.valid = d_q.req_sy[2] ^ d_q.req_sy[1];
    if (d_d.valid) begin
      d_d.data = s_q.hold;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      d_q <= '0;
    end else begin
      d_q <= d_d;
    end
  end
endmodule // alfi_xfer_cdc

/* hdl/alfi_link_frame.sv */
// What this block does
// - Outbound data carries a bit on both clock edges.
// - Codec captures each outbound and sync bit on the following edge.
// - Codec changes inbound data only on rising edges, one bit per clock.
// - Link reset low returns the bit-clock logic to its power-on state; clk-side state resets on rst only.
// - A frame runs from one sync falling edge to the next.
// - Each frame starts with one command or response field, MSB first.
// - Command is the first 40 outbound bits, response the first 36 inbound.
// - Null field bits are sent as zero.
// - A sample block holds channel-count equal-size samples, unpadded, fixed order.
// - Each packet begins with a tag and holds one stream only.
// - Outbound tag is 1110 preamble then 4-bit stream id on sync.
// - Outbound tag lines up with the last eight bits of the previous field.
// - Inbound packet starts with 4-bit stream id and 6-bit byte length.
// - First inbound packet follows the response field directly.
// - After the last inbound packet a zero-length tag, then null bits.
// - With under ten positions left, skip the end tag and send nulls.
// - Codec requests initialization before the 25th sync after reset.
`timescale 1ns/1ns
module alfi_link_frame #(
  parameter int SW = 16,
  parameter int CH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_clk,
  input wire logic link_reset_n,
  input wire logic frame_sync,
  input wire logic out_data,
  input wire logic in_data_i,
  output logic in_data_o,
  output logic in_data_oe,
  input wire logic [alfi_pkg::SID_W-1:0] cfg_out_id,
  input wire logic [alfi_pkg::SID_W-1:0] cfg_in_id,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_rsp_valid,
  input wire logic [alfi_pkg::RSP_BITS-1:0] in_rsp,
  input wire logic in_blk_valid,
  input wire logic [CH*SW-1:0] in_blk,
  output logic cmd_valid,
  output logic [alfi_pkg::CMD_BITS-1:0] cmd_word,
  output logic smp_valid,
  output logic [SW-1:0] smp_data,
  output logic [((CH > 1) ? $clog2(CH) : 1)-1:0] smp_ch,
  output logic link_ready,
  output logic [alfi_pkg::SID_W-1:0] codec_addr
);
  import alfi_pkg::*;

  // ==========================================================
  // Sizes
  localparam int CHW = (CH > 1) ? $clog2(CH) : 1;
  localparam int LW = CHW + 1;
  localparam int SWW = $clog2(SW + 1);
  localparam int BLK = CH * SW;
  localparam int HEAD_LEN = RSP_BITS + IN_TAG_BITS + BLK;
  localparam int TERM_LEN = (FRAME_BITS - HEAD_LEN >= IN_TAG_BITS) ? IN_TAG_BITS : 0;
  localparam int IN_LEN = HEAD_LEN + TERM_LEN;
  localparam int INW = 2 * SID_W + 2 + RSP_BITS + BLK;
  localparam logic [LEN_W-1:0] BLK_BYTES = LEN_W'(BLK / 8);

  // ==========================================================
  // Link reset: asserts at once, releases on the bit clock
  logic lrst_async;
  logic [1:0] lrst_sy_q;
  logic lrst;

  assign lrst_async = rst | ~link_reset_n;
  assign lrst = ~lrst_sy_q[1];

  always_ff @(posedge bit_clk or posedge lrst_async) begin
    if (lrst_async) begin
      lrst_sy_q <= 2'h0;
    end else begin
      lrst_sy_q <= {lrst_sy_q[0], 1'b1};
    end
  end

  // ==========================================================
  // Falling edge capture, paired with the rising sample next
  logic sync_neg_q;
  logic sdo_neg_q;

  always_ff @(negedge bit_clk or posedge lrst) begin
    if (lrst) begin
      sync_neg_q <= 1'b0;
      sdo_neg_q <= 1'b0;
    end else begin
      sync_neg_q <= frame_sync;
      sdo_neg_q <= out_data;
    end
  end

  // ==========================================================
  // Crossings
  alfi_xfer_if #(.W(CMD_BITS)) cmd_x ();
  alfi_xfer_if #(.W(SW + CHW)) smp_x ();
  alfi_xfer_if #(.W(INW)) in_x ();

  alfi_xfer_cdc #(.W(CMD_BITS)) u_cmd_cdc (
    .src_clk(bit_clk),
    .src_rst(lrst),
    .dst_clk(clk),
    .dst_rst(rst),
    .x(cmd_x.cdc)
  );

  alfi_xfer_cdc #(.W(SW + CHW)) u_smp_cdc (
    .src_clk(bit_clk),
    .src_rst(lrst),
    .dst_clk(clk),
    .dst_rst(rst),
    .x(smp_x.cdc)
  );

  alfi_xfer_cdc #(.W(INW)) u_in_cdc (
    .src_clk(clk),
    .src_rst(rst),
    .dst_clk(bit_clk),
    .dst_rst(lrst),
    .x(in_x.cdc)
  );

  // ==========================================================
  // Link state
  typedef struct packed {
    alfi_phase_type phase;
    logic up;
    logic [7:0] sync_sh;
    logic [POS_W-1:0] pos;
    logic [CMD_BITS-1:0] cmd_sh;
    logic acc;
    logic [LW-1:0] left;
    logic [SWW-1:0] bcnt;
    logic [CHW-1:0] ch;
    logic [SW-1:0] samp;
    logic sdi;
    logic oe;
    logic [IN_LEN-1:0] in_sh;
    logic rsp_v;
    logic [RSP_BITS-1:0] rsp;
    logic blk_v;
    logic [BLK-1:0] blk;
    logic [SID_W-1:0] out_id;
    logic [SID_W-1:0] in_id;
    logic [SID_W-1:0] addr;
    logic [SID_W-1:0] acnt;
  } alfi_link_type;

  alfi_link_type l_q;
  alfi_link_type l_d;
  logic [7:0] w;
  logic fs;
  logic tag;
  logic run;
  logic cmd_push;
  logic smp_push;
  logic [IN_LEN-1:0] word;

  assign in_data_o = l_q.sdi;
  assign in_data_oe = l_q.oe;
  assign cmd_x.src_valid = cmd_push;
  assign cmd_x.src_data = l_d.cmd_sh;
  assign smp_x.src_valid = smp_push;
  assign smp_x.src_data = {l_d.samp, l_q.ch};

  always_comb begin
    l_d = l_q;
    cmd_push = 1'b0;
    smp_push = 1'b0;
    w = {l_q.sync_sh[5:0], sync_neg_q, frame_sync};
    fs = (l_q.sync_sh == 8'hff) && !sync_neg_q;
    tag = (w[7:4] == OUT_PREAMBLE) && !l_q.sync_sh[6];
    run = (l_q.phase == L_NORMAL) || ((l_q.phase == L_READY) && fs);
    word = IN_LEN'({(l_q.rsp_v ? l_q.rsp : RSP_BITS'(0)),
                   ((l_q.blk_v && l_q.in_id != '0) ?
                    {l_q.in_id, BLK_BYTES, l_q.blk} :
                    (IN_TAG_BITS + BLK)'(0))}) << TERM_LEN;
    l_d.sync_sh = w;
    if (fs) begin
      l_d.pos = POS_W'(1);
    end else if (l_q.pos != POS_W'(FRAME_BITS - 1)) begin
      l_d.pos = l_q.pos + 1'b1;
    end
    // Init frames: outbound traffic is ignored here
    case (l_q.phase)
      L_CONNECT: begin
        if ({l_q.sync_sh[3:0], sync_neg_q, frame_sync} == SYNC_LAST_CLK) begin
          l_d.sdi = 1'b1;
          l_d.oe = 1'b1;
        end
        if (fs) begin
          l_d.sdi = 1'b0;
          l_d.phase = L_TURN;
        end
      end
      L_TURN: begin
        l_d.sdi = 1'b0;
        l_d.oe = 1'b0;
        if (fs) begin
          l_d.phase = L_ADDR;
          l_d.acnt = '0;
        end
      end
      L_ADDR: begin
        if (!frame_sync && !in_data_i) begin
          l_d.addr = l_q.acnt;
          l_d.phase = L_READY;
        end else if (l_q.acnt != ADDR_MAX) begin
          l_d.acnt = l_q.acnt + 1'b1;
        end
      end
      L_READY: begin
        if (fs) begin
          l_d.phase = L_NORMAL;
        end
      end
      L_NORMAL: begin
      end
      default: begin
        l_d.phase = L_CONNECT;
      end
    endcase
    if (run) begin
      l_d.oe = 1'b1;
      // Command field, two bits per bit clock, MSB first
      if (fs || (l_q.pos < POS_W'(CMD_PAIRS))) begin
        l_d.cmd_sh = {l_q.cmd_sh[CMD_BITS-3:0], sdo_neg_q, out_data};
        cmd_push = !fs && (l_q.pos == POS_W'(CMD_PAIRS - 1));
      end
      // Sample data for the accepted stream
      if (!fs && l_q.acc && (l_q.left != '0)) begin
        l_d.samp = {l_q.samp[SW-3:0], sdo_neg_q, out_data};
        l_d.bcnt = l_q.bcnt + SWW'(2);
        if (l_q.bcnt == SWW'(SW - 2)) begin
          smp_push = 1'b1;
          l_d.bcnt = '0;
          l_d.left = l_q.left - 1'b1;
          l_d.ch = l_q.ch + 1'b1;
        end
      end
      // The tag sits on the previous field's last bits, so data starts next
      if (tag && !fs) begin
        l_d.acc = (w[3:0] == l_q.out_id) && (l_q.out_id != '0);
        l_d.left = LW'(CH);
        l_d.bcnt = '0;
        l_d.ch = '0;
      end
      if (fs) begin
        l_d.acc = 1'b0;
        l_d.sdi = word[IN_LEN-1];
        l_d.in_sh = {word[IN_LEN-2:0], 1'b0};
        l_d.rsp_v = 1'b0;
        l_d.blk_v = 1'b0;
      end else begin
        l_d.sdi = l_q.in_sh[IN_LEN-1];
        l_d.in_sh = {l_q.in_sh[IN_LEN-2:0], 1'b0};
      end
    end
    // New words arriving in the load cycle are kept, not lost
    if (in_x.dst_valid) begin
      {l_d.out_id, l_d.in_id} = in_x.dst_data[INW-1 -: 2 * SID_W];
      if (in_x.dst_data[BLK + RSP_BITS + 1]) begin
        l_d.rsp_v = 1'b1;
        l_d.rsp = in_x.dst_data[BLK + 1 +: RSP_BITS];
      end
      if (in_x.dst_data[BLK]) begin
        l_d.blk_v = 1'b1;
        l_d.blk = in_x.dst_data[BLK-1:0];
      end
    end
    l_d.up = (l_d.phase == L_NORMAL);
  end

  always_ff @(posedge bit_clk or posedge lrst) begin
    if (lrst) begin
      l_q <= '0;
      l_q.phase <= L_CONNECT;
    end else begin
      l_q <= l_d;
    end
  end

  // ==========================================================
  // System side
  typedef struct packed {
    logic [1:0] up_sy;
    logic up;
    logic [SID_W-1:0] addr;
  } alfi_sys_type;

  alfi_sys_type s_q;
  alfi_sys_type s_d;

  assign in_x.src_valid = in_valid;
  assign in_x.src_data = {cfg_out_id, cfg_in_id, in_rsp_valid, in_rsp, in_blk_valid, in_blk};
  assign in_ready = !in_x.src_busy;
  assign cmd_valid = cmd_x.dst_valid;
  assign cmd_word = cmd_x.dst_data;
  assign smp_valid = smp_x.dst_valid;
  assign {smp_data, smp_ch} = smp_x.dst_data;
  assign link_ready = s_q.up;
  assign codec_addr = s_q.addr;

  always_comb begin
    s_d = s_q;
    s_d.up_sy = {s_q.up_sy[0], l_q.up};
    s_d.up = s_q.up_sy[1];
    // Address is static long before the ready level gets here
    if (s_q.up_sy[1] && !s_q.up) begin
      s_d.addr = l_q.addr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Checks
  logic [IN_LEN-1:0] ld_q;

  always_ff @(posedge bit_clk or posedge lrst) begin
    if (lrst) begin
      ld_q <= '0;
    end else if (run && fs) begin
      ld_q <= word;
    end
  end

  default clocking cb @(posedge bit_clk); endclocking
  default disable iff (lrst);

  chk_frame_start: assert property (run && fs |=> l_q.pos == POS_W'(1))
    else $error("frame position not restarted at sync fall");
  chk_in_layout: assert property ((l_q.phase == L_NORMAL) && (l_q.pos >= POS_W'(1)) &&
      (l_q.pos <= POS_W'(IN_LEN)) |-> l_q.sdi == ld_q[IN_LEN - l_q.pos])
    else $error("inbound bit differs from loaded frame");
  chk_null_tail: assert property ((l_q.phase == L_NORMAL) && (l_q.pos > POS_W'(IN_LEN))
      |-> !l_q.sdi && l_q.oe)
    else $error("null field not zero");
  chk_cmd_push: assert property (run && !fs && (l_q.pos == POS_W'(CMD_PAIRS - 1))
      |-> cmd_push && !cmd_x.src_busy ##1 !cmd_push)
    else $error("command not pushed after forty bits");
  chk_tag_skip: assert property (run && tag && !fs && (w[3:0] != l_q.out_id)
      |=> !l_q.acc && !smp_push)
    else $error("foreign stream packet accepted");
  chk_sample_limit: assert property (smp_push |-> l_q.acc && (l_q.left != '0) &&
      (l_q.bcnt == SWW'(SW - 2)) && !smp_x.src_busy)
    else $error("sample pushed outside block");
  chk_init_request: assert property ((l_q.phase == L_CONNECT) && fs
      |-> l_q.sdi && l_q.oe)
    else $error("no init request at first sync");
  chk_turnaround: assert property ((l_q.phase == L_CONNECT) && fs
      |=> (l_q.oe && !l_q.sdi) ##1 !l_q.oe)
    else $error("turnaround sequence wrong");
  chk_link_reset: assert property ($past(lrst) && !lrst
      |-> (l_q.phase == L_CONNECT) && !l_q.oe && !l_q.sdi)
    else $error("link logic not at default after reset");

  cov_rsp_sent: cover property (run && fs && l_q.rsp_v && l_q.blk_v);
  cov_sample: cover property (smp_push);
  cov_ready: cover property ((l_q.phase == L_READY) ##1 (l_q.phase == L_NORMAL));
endmodule // alfi_link_frame

/* tb/alfi_ctrl_model.sv */
`timescale 1ns/1ns
// ==================================================
// Host controller at the far end of the link
module alfi_ctrl_model (
  input wire logic bit_clk,
  output logic link_reset_n,
  output logic frame_sync,
  output logic out_data,
  input wire logic in_data_o,
  input wire logic in_data_oe,
  output logic in_wire
);
  import alfi_pkg::*;
  logic drv_oe = 1'h0;
  logic drv = 1'h0;
  logic req = 1'h0;
  logic [0:FRAME_BITS-1] rx;
  initial begin
    link_reset_n = 1'h0;
    frame_sync = 1'h0;
    out_data = 1'h0;
  end
  // Weak pull-down: nobody driving reads low
  assign in_wire = in_data_oe ? in_data_o : (drv_oe ? drv : 1'h0);
  task automatic release_reset();
    repeat (8) @(posedge bit_clk);
    link_reset_n <= 1'h1;
  endtask
  // Mode 1 drives inbound high in the last sync, mode 2 hands out addr
  task automatic frame(input logic [39:0] cmd, input logic [3:0] tid,
    input logic [31:0] blk, input int mode, input logic [3:0] addr);
    logic [7:0] tag8;
    logic s;
    int h;
    tag8 = {OUT_PREAMBLE, tid};
    for (int i = 0; i < FRAME_BITS; i++) begin
      @(posedge bit_clk);
      if (i >= 2) rx[i-2] = in_wire;
      for (int k = 0; k < 2; k++) begin
        h = 2 * i + k;
        if (k == 1) @(negedge bit_clk);
        // Sync mark closes each frame, first sync comes late after reset
        s = i >= FRAME_BITS - SYNC_MARK_CLKS;
        if (tid != 4'h0 && h >= 32 && h < 40) s = tag8[39-h];
        frame_sync <= s;
        out_data <= h < CMD_BITS ? cmd[39-h] :
          (tid != 4'h0 && h < 72) ? blk[71-h] : 1'h0;
      end
      drv_oe <= (mode == 1 && i >= FRAME_BITS - SYNC_MARK_CLKS) || (mode == 2 && i < 17);
      // One clock longer, as the codec counts from the edge after it sees the frame start
      drv <= mode == 1 || i <= addr;
      // The request rises on the last sync clock, so it is only visible after that edge
      if (i == FRAME_BITS - 1) req = in_wire;
    end
  endtask
endmodule // alfi_ctrl_model

/* tb/test_alfi_link_frame.sv */
`timescale 1ns/1ns
// ==================================================
// Self-checking bench for the link framer
module test_alfi_link_frame;
  import alfi_pkg::*;
  localparam int SW = 16;
  localparam int CH = 2;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic bit_clk = 1'h0;
  logic link_reset_n, frame_sync, out_data, in_wire, in_data_o, in_data_oe;
  logic [SID_W-1:0] cfg_out_id = 4'h0;
  logic [SID_W-1:0] cfg_in_id = 4'h0;
  logic in_valid = 1'h0;
  logic in_rsp_valid = 1'h0;
  logic [RSP_BITS-1:0] in_rsp = 36'h0;
  logic in_blk_valid = 1'h0;
  logic [CH*SW-1:0] in_blk = 32'h0;
  logic in_ready, cmd_valid, smp_valid, link_ready;
  logic [CMD_BITS-1:0] cmd_word;
  logic [SW-1:0] smp_data;
  logic [0:0] smp_ch;
  logic [SID_W-1:0] codec_addr;
  logic [63:0] cmd_q[$];
  logic [63:0] smp_q[$];
  int fails = 0;
  int total_checks = 0;
  integer seed = 58;
  initial forever #5 clk = ~clk;
  initial begin
    #7;
    forever #15 bit_clk = ~bit_clk;
  end
  alfi_link_frame #(.SW(SW), .CH(CH)) alfi_link_frame_i (.clk(clk), .rst(rst),
    .bit_clk(bit_clk), .link_reset_n(link_reset_n), .frame_sync(frame_sync),
    .out_data(out_data), .in_data_i(in_wire), .in_data_o(in_data_o),
    .in_data_oe(in_data_oe), .cfg_out_id(cfg_out_id), .cfg_in_id(cfg_in_id),
    .in_valid(in_valid), .in_ready(in_ready), .in_rsp_valid(in_rsp_valid),
    .in_rsp(in_rsp), .in_blk_valid(in_blk_valid), .in_blk(in_blk),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .smp_valid(smp_valid),
    .smp_data(smp_data), .smp_ch(smp_ch), .link_ready(link_ready),
    .codec_addr(codec_addr));
  alfi_ctrl_model alfi_ctrl_model_i (.bit_clk(bit_clk), .link_reset_n(link_reset_n),
    .frame_sync(frame_sync), .out_data(out_data), .in_data_o(in_data_o),
    .in_data_oe(in_data_oe), .in_wire(in_wire));
  // ==================================================
  // Compare and finish
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Unexpected pulses count as mismatches, so skipped packets are seen
  always @(posedge clk) begin
    if (cmd_valid === 1'h1) begin
      if (cmd_q.size() == 0) check("cmd_extra", 64'h1, 64'h0);
      else check("cmd", 64'(cmd_word), cmd_q.pop_front());
    end
    if (smp_valid === 1'h1) begin
      if (smp_q.size() == 0) check("smp_extra", 64'h1, 64'h0);
      else check("smp", 64'({smp_ch, smp_data}), smp_q.pop_front());
    end
  end
  // Wait well past the frame start so the word lands in the next frame
  task automatic offer(input logic [3:0] in_id, input logic [35:0] rsp, input logic [31:0] blk);
    repeat (20) @(posedge clk);
    while (in_ready !== 1'h1) @(posedge clk);
    in_valid <= 1'h1;
    cfg_out_id <= 4'h5;
    cfg_in_id <= in_id;
    in_rsp_valid <= 1'h1;
    in_rsp <= rsp;
    in_blk_valid <= 1'h1;
    in_blk <= blk;
    @(posedge clk);
    in_valid <= 1'h0;
  endtask
  // ==================================================
  // Main sequence
  initial begin
    logic [39:0] cmd;
    logic [31:0] d, b, pb;
    logic [35:0] r, pr;
    logic [3:0] addr, tid, pid;
    int cnt;
    int ones;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check("link_rst", 64'({in_data_oe, in_data_o}), 64'h0);
    alfi_ctrl_model_i.release_reset();
    cnt = 0;
    do begin
      alfi_ctrl_model_i.frame(40'h0, 4'h0, 32'h0, 0, 4'h0);
      cnt++;
    end while (alfi_ctrl_model_i.req !== 1'h1 && cnt < INIT_SYNC_LIMIT);
    check("init_req", 64'(alfi_ctrl_model_i.req), 64'h1);
    addr = 4'($random(seed));
    if (addr == 4'hf) addr = 4'he;
    alfi_ctrl_model_i.frame(40'h0, 4'h0, 32'h0, 1, 4'h0);
    alfi_ctrl_model_i.frame(40'h0, 4'h0, 32'h0, 2, addr);
    pid = 4'h0;
    pr = 36'h0;
    pb = 32'h0;
    for (int n = 0; n < 5; n++) begin
      cmd = {8'($random(seed)), 32'($random(seed))};
      d = $random(seed);
      b = $random(seed);
      r = {4'($random(seed)), 32'($random(seed))};
      tid = (n == 3) ? 4'h9 : 4'h5;
      cmd_q.push_back(64'(cmd));
      if (tid == 4'h5) begin
        smp_q.push_back({47'h0, 1'h0, d[31:16]});
        smp_q.push_back({47'h0, 1'h1, d[15:0]});
      end
      fork
        offer((n % 2 == 0) ? 4'h3 : 4'h0, r, b);
        alfi_ctrl_model_i.frame(cmd, tid, d, 0, 4'h0);
      join
      if (n == 0) check("addr", 64'({link_ready, codec_addr}), {59'h0, 1'h1, addr});
      if (n > 0) begin
        check("rsp", 64'(alfi_ctrl_model_i.rx[0:35]), 64'(pr));
        cnt = RSP_BITS;
        if (pid != 4'h0) begin
          check("in_tag", 64'(alfi_ctrl_model_i.rx[36:45]),
            {54'h0, pid, 6'(CH*SW/8)});
          check("in_blk", 64'(alfi_ctrl_model_i.rx[46:77]), 64'(pb));
          cnt = 78;
        end
        ones = 0;
        for (int k = cnt; k < FRAME_BITS - 10; k++) begin
          if (alfi_ctrl_model_i.rx[k] !== 1'h0) ones++;
        end
        check("null", 64'(ones), 64'h0);
      end
      pid = (n % 2 == 0) ? 4'h3 : 4'h0;
      pr = r;
      pb = b;
    end
    repeat (10) @(posedge clk);
    check("pending", 64'(cmd_q.size() + smp_q.size()), 64'h0);
    end_sim();
  end
  // Worst case is 32 frames of 15 us
  initial begin
    #800000;
    fails++;
    end_sim();
  end
endmodule // test_alfi_link_frame
